// file: hdl/pcs_consts.svh
// Constants for the counter, return stack and indirect address block.
// Assumes inclusion by bare name from the design file.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
// Register port offsets
`define PCS_A_PCL      4'h0
`define PCS_A_LATCH    4'h1
`define PCS_A_SP       4'h2
`define PCS_A_TOP_OF_STACK_LOW     4'h3
`define PCS_A_TOP_OF_STACK_HIGH     4'h4
`define PCS_A_F0L      4'h5
`define PCS_A_F0H      4'h6
`define PCS_A_F1L      4'h7
`define PCS_A_F1H      4'h8
`define PCS_A_PWR      4'h9
// Flag positions in the power control register
`define PCS_OVF_BIT    1
`define PCS_UNF_BIT    0
// Reset values, interrupt vector and stack limits
`define PCS_SP_EMPTY   5'h1F
`define PCS_SP_LAST    5'h0F
`define PCS_PC_RST     15'h0000
`define PCS_INT_VEC    15'h0004
// Indirect address map
`define PCS_TRAD_LAST  16'h0FFF
`define PCS_LIN_BASE   16'h2000
`define PCS_LIN_LAST   16'h29AF
`define PCS_GPR_LEN    12'h0050
`define PCS_GPR_OFS    7'h20
`define PCS_SELF_LAST  7'h01
`endif

// file: hdl/pcs_pkg.sv
// Types for the counter, return stack and indirect address block.
// Assumes nothing beyond a SystemVerilog compiler.
package pcs_pkg;
  // Control-flow operations from the decoder
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_STEP  = 4'h1,
    OP_CALL  = 4'h2,
    OP_COMPUTED_CALL_OP = 4'h3,
    OP_BRW   = 4'h4,
    OP_BRA   = 4'h5,
    OP_RET   = 4'h6,
    OP_INTR  = 4'h7
  } pcs_op_t;
  // Indirect access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ISSUE = 4'h2,
    ST_FWAIT = 4'h4,
    ST_CAPT  = 4'h8
  } pcs_st_t;
endpackage

// file: hdl/pcs_core.sv
// Program counter loading, 16-entry return stack and indirect translation.
// Assumes decoder, memories and register port on I_CORE_CLK, sync reset.
`timescale 1ns/1ns
`include "pcs_consts.svh"
module pcs_core (
  // Clock and resets
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RST,
  input  wire logic             I_POR_RST,
  // Configuration
  input  wire logic             I_STACK_FAULT_RESET_EN,
  // Decoder side
  input  wire logic             I_OP_VALID,
  input  wire pcs_pkg::pcs_op_t I_OP,
  input  wire logic [10:0]      I_OPERAND,
  input  wire logic [7:0]       I_WREG,
  // Register port
  input  wire logic [3:0]       I_REG_ADDR,
  input  wire logic [7:0]       I_REG_WDATA,
  input  wire logic             I_REG_WR,
  input  wire logic             I_REG_RD,
  output logic [7:0]            O_REG_RDATA,
  // Counter and stack status
  output logic [14:0]           O_PC,
  output logic                  O_STACK_FAULT_RST,
  // Indirect access request
  input  wire logic             I_IND_REQ,
  input  wire logic             I_IND_SEL,
  input  wire logic             I_IND_WR,
  input  wire logic [7:0]       I_IND_WDATA,
  output logic                  O_IND_BUSY,
  output logic                  O_IND_DONE,
  output logic [7:0]            O_IND_RDATA,
  // Data memory
  output logic [11:0]           O_MEM_ADDR,
  output logic                  O_MEM_RD,
  output logic                  O_MEM_WR,
  output logic [7:0]            O_MEM_WDATA,
  input  wire logic [7:0]       I_MEM_RDATA,
  // Program flash, read only
  output logic [14:0]           O_FLASH_ADDR,
  output logic                  O_FLASH_RD,
  input  wire logic [13:0]      I_FLASH_RDATA
);

  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [6:0]  latch_q;
  logic [4:0]  sp_q;
  logic [4:0]  sp_d;
  logic [14:0] stk_q [16];
  logic [14:0] tos_raw;
  logic [14:0] tos_rd;
  logic [15:0] fsr_q [2];
  logic        ovf_q;
  logic        unf_q;
  logic        push;
  logic        pop;
  logic        ovf_ev;
  logic        unf_ev;
  logic        pcl_wr;
  logic        stk_wr;
  logic [3:0]  stk_idx;
  logic [14:0] stk_val;
  logic [14:0] pc_inc;
  logic [7:0]  rdata_d;

  // Register port decode
  assign pcl_wr = I_REG_WR && (I_REG_ADDR == `PCS_A_PCL);

  // Stack actions from the decoder; latch is never touched here
  assign push   = I_OP_VALID && ((I_OP == pcs_pkg::OP_CALL) || (I_OP == pcs_pkg::OP_COMPUTED_CALL_OP)
                  || (I_OP == pcs_pkg::OP_INTR));
  assign pop    = I_OP_VALID && (I_OP == pcs_pkg::OP_RET);
  // Push with the pointer at or past the last valid index, but not empty, means overflow
  assign ovf_ev = push && (sp_q >= `PCS_SP_LAST) && (sp_q != `PCS_SP_EMPTY);
  assign unf_ev = pop && (sp_q == `PCS_SP_EMPTY);
  assign pc_inc = pc_q + 15'h0001;

  // Top of stack: low four pointer bits pick the entry, so 0x1F shows 0x0F unless I_STACK_FAULT_RESET_EN zeroes the read
  assign tos_raw = stk_q[sp_q[3:0]];
  assign tos_rd  = (sp_q == `PCS_SP_EMPTY && I_STACK_FAULT_RESET_EN) ? 15'h0000 : tos_raw;

  // Next counter; a low-byte write wins over a decoder load in the same cycle
  always_comb
  begin
    pc_d = pc_q;
    if (pcl_wr)
      pc_d = {latch_q, I_REG_WDATA};
    else if (I_OP_VALID)
    begin
      case (I_OP)
        pcs_pkg::OP_STEP:  pc_d = pc_inc;
        pcs_pkg::OP_CALL:  pc_d = {latch_q[6:3], I_OPERAND};
        pcs_pkg::OP_COMPUTED_CALL_OP: pc_d = {latch_q, I_WREG};
        pcs_pkg::OP_BRW:   pc_d = pc_inc + {7'h00, I_WREG};
        pcs_pkg::OP_BRA:   pc_d = pc_inc + {{6{I_OPERAND[8]}}, I_OPERAND[8:0]};
        pcs_pkg::OP_RET:   pc_d = tos_raw;
        pcs_pkg::OP_INTR:  pc_d = `PCS_INT_VEC;
        default:           pc_d = pc_q;
      endcase
    end
  end

  // Counter register, cleared by any reset
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      pc_q <= `PCS_PC_RST;
    else
      pc_q <= pc_d;
  end

  // Counter latch, written only through the register port
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      latch_q <= 7'h00;
    else if (I_REG_WR && I_REG_ADDR == `PCS_A_LATCH)
      latch_q <= I_REG_WDATA[6:0];
  end

  // Pointer: a software write wins over push or pop
  always_comb
  begin
    sp_d = sp_q;
    if (I_REG_WR && I_REG_ADDR == `PCS_A_SP)
      sp_d = I_REG_WDATA[4:0];
    else if (push)
      sp_d = sp_q + 5'h01;
    else if (pop)
      sp_d = sp_q - 5'h01;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      sp_q <= `PCS_SP_EMPTY;
    else
      sp_q <= sp_d;
  end

  // Stack write port; push writes at the incremented index, wrapping
  always_comb
  begin
    stk_wr  = 1'b0;
    stk_idx = sp_q[3:0];
    stk_val = tos_raw;
    if (push)
    begin
      stk_wr  = 1'b1;
      stk_idx = sp_d[3:0];
      stk_val = (I_OP == pcs_pkg::OP_INTR) ? pc_q : pc_inc;
    end
    else if (I_REG_WR && I_REG_ADDR == `PCS_A_TOP_OF_STACK_LOW)
    begin
      stk_wr  = 1'b1;
      stk_val = {tos_raw[14:8], I_REG_WDATA};
    end
    else if (I_REG_WR && I_REG_ADDR == `PCS_A_TOP_OF_STACK_HIGH)
    begin
      stk_wr  = 1'b1;
      stk_val = {I_REG_WDATA[6:0], tos_raw[7:0]};
    end
  end

  // Sixteen private entries, in neither address space
  for (genvar g = 0; g < 16; g++)
  begin : g_stk
    always_ff @(posedge I_CORE_CLK)
    begin
      if (I_POR_RST)
        stk_q[g] <= 15'h0000;
      else if (stk_wr && stk_idx == 4'(g))
        stk_q[g] <= stk_val;
    end
  end

  // Fault flags survive core reset so software can see why it restarted;
  // writing 0 clears, a fresh fault in the same cycle wins
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_POR_RST)
    begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end
    else
    begin
      if (ovf_ev)
        ovf_q <= 1'b1;
      else if (I_REG_WR && I_REG_ADDR == `PCS_A_PWR)
        ovf_q <= ovf_q & I_REG_WDATA[`PCS_OVF_BIT];
      if (unf_ev)
        unf_q <= 1'b1;
      else if (I_REG_WR && I_REG_ADDR == `PCS_A_PWR)
        unf_q <= unf_q & I_REG_WDATA[`PCS_UNF_BIT];
    end
  end

  // Reset request pulse to the system reset logic
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      O_STACK_FAULT_RST <= 1'b0;
    else
      O_STACK_FAULT_RST <= (ovf_ev || unf_ev) && I_STACK_FAULT_RESET_EN;
  end

  // Pointer byte registers, each pair one 16-bit pointer
  for (genvar p = 0; p < 2; p++)
  begin : g_fsr
    always_ff @(posedge I_CORE_CLK)
    begin
      if (I_RST || I_POR_RST)
        fsr_q[p] <= 16'h0000;
      else if (I_REG_WR && I_REG_ADDR == 4'(`PCS_A_F0L + 2 * p))
        fsr_q[p][7:0] <= I_REG_WDATA;
      else if (I_REG_WR && I_REG_ADDR == 4'(`PCS_A_F0H + 2 * p))
        fsr_q[p][15:8] <= I_REG_WDATA;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (I_REG_ADDR)
      `PCS_A_PCL:   rdata_d = pc_q[7:0];
      `PCS_A_LATCH: rdata_d = {1'b0, latch_q};
      `PCS_A_SP:    rdata_d = {3'h0, sp_q};
      `PCS_A_TOP_OF_STACK_LOW:  rdata_d = tos_rd[7:0];
      `PCS_A_TOP_OF_STACK_HIGH:  rdata_d = {1'b0, tos_rd[14:8]};
      `PCS_A_F0L:   rdata_d = fsr_q[0][7:0];
      `PCS_A_F0H:   rdata_d = fsr_q[0][15:8];
      `PCS_A_F1L:   rdata_d = fsr_q[1][7:0];
      `PCS_A_F1H:   rdata_d = fsr_q[1][15:8];
      `PCS_A_PWR:   rdata_d = {6'h00, ovf_q, unf_q};
      default:      rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      O_REG_RDATA <= 8'h00;
    else if (I_REG_RD)
      O_REG_RDATA <= rdata_d;
  end

  assign O_PC = pc_q;

  // Indirect translation of the selected pointer
  pcs_pkg::pcs_st_t st_q;
  logic [15:0] ind_ptr;
  logic [11:0] lin_ofs;
  logic [11:0] lin_bank;
  logic [11:0] lin_idx;
  logic        is_flash;
  logic        is_zero;
  logic [11:0] ind_addr;
  logic        zero_q;
  logic        flash_sel_q;

  assign ind_ptr  = fsr_q[I_IND_SEL];
  assign lin_ofs  = 12'(ind_ptr - `PCS_LIN_BASE);
  assign lin_bank = lin_ofs / `PCS_GPR_LEN;
  assign lin_idx  = lin_ofs % `PCS_GPR_LEN;
  assign is_flash = ind_ptr[15];

  // Decode region; indirect locations and holes give zero
  always_comb
  begin
    ind_addr = ind_ptr[11:0];
    is_zero  = 1'b0;
    if (is_flash)
      is_zero = 1'b0;
    else if (ind_ptr <= `PCS_TRAD_LAST)
      is_zero = (ind_ptr[6:0] <= `PCS_SELF_LAST);
    else if (ind_ptr >= `PCS_LIN_BASE && ind_ptr <= `PCS_LIN_LAST)
      ind_addr = {lin_bank[4:0], `PCS_GPR_OFS + lin_idx[6:0]};
    else
      is_zero = 1'b1;
  end

  assign O_IND_BUSY = (st_q != pcs_pkg::ST_IDLE);

  // Sequencer: strobe, wait on flash, capture, then pulse done
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
    begin
      st_q         <= pcs_pkg::ST_IDLE;
      zero_q       <= 1'b0;
      O_MEM_ADDR   <= 12'h000;
      O_MEM_RD     <= 1'b0;
      O_MEM_WR     <= 1'b0;
      O_MEM_WDATA  <= 8'h00;
      O_FLASH_ADDR <= 15'h0000;
      O_FLASH_RD   <= 1'b0;
      O_IND_DONE   <= 1'b0;
      O_IND_RDATA  <= 8'h00;
    end
    else
    begin
      O_MEM_RD   <= 1'b0;
      O_MEM_WR   <= 1'b0;
      O_FLASH_RD <= 1'b0;
      O_IND_DONE <= 1'b0;
      case (st_q)
        pcs_pkg::ST_IDLE:
        begin
          if (I_IND_REQ)
          begin
            st_q         <= pcs_pkg::ST_ISSUE;
            zero_q       <= is_zero;
            O_MEM_ADDR   <= ind_addr;
            O_MEM_WDATA  <= I_IND_WDATA;
            O_FLASH_ADDR <= ind_ptr[14:0];
            O_FLASH_RD   <= is_flash && !I_IND_WR;
            O_MEM_RD     <= !is_flash && !is_zero && !I_IND_WR;
            O_MEM_WR     <= !is_flash && !is_zero && I_IND_WR;
            zero_q       <= is_zero || (is_flash && I_IND_WR);
          end
        end
        pcs_pkg::ST_ISSUE:
          st_q <= O_FLASH_RD ? pcs_pkg::ST_FWAIT : pcs_pkg::ST_CAPT;
        pcs_pkg::ST_FWAIT:
          st_q <= pcs_pkg::ST_CAPT;
        pcs_pkg::ST_CAPT:
        begin
          st_q       <= pcs_pkg::ST_IDLE;
          O_IND_DONE <= 1'b1;
          if (zero_q)
            O_IND_RDATA <= 8'h00;
          else if (O_FLASH_ADDR != 15'h0000 || st_q == pcs_pkg::ST_CAPT)
            O_IND_RDATA <= flash_sel_q ? I_FLASH_RDATA[7:0] : I_MEM_RDATA;
        end
        default:
          st_q <= pcs_pkg::ST_IDLE;
      endcase
    end
  end

  // Remembers whether the access in flight targets flash, read or write
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || I_POR_RST)
      flash_sel_q <= 1'b0;
    else if (st_q == pcs_pkg::ST_IDLE && I_IND_REQ)
      flash_sel_q <= is_flash;
  end

  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST || I_POR_RST);

  logic op_ok;
  assign op_ok = I_OP_VALID && !pcl_wr && !(I_REG_WR && I_REG_ADDR == `PCS_A_LATCH);

  a_call_load: assert property (op_ok && I_OP == pcs_pkg::OP_CALL |=>
    pc_q == {$past(latch_q[6:3]), $past(I_OPERAND)}) else $error("call target wrong");
  a_computed_call_op_load: assert property (op_ok && I_OP == pcs_pkg::OP_COMPUTED_CALL_OP |=>
    pc_q == {$past(latch_q), $past(I_WREG)}) else $error("computed call target wrong");
  a_brw_target: assert property (op_ok && I_OP == pcs_pkg::OP_BRW |=>
    pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(I_WREG)}) else $error("register branch wrong");
  a_bra_target: assert property (op_ok && I_OP == pcs_pkg::OP_BRA |=>
    pc_q == $past(pc_q) + 15'h0001 + {{6{$past(I_OPERAND[8])}}, $past(I_OPERAND[8:0])})
    else $error("operand branch wrong");
  a_push_tos: assert property (push && !I_REG_WR |=>
    sp_q == $past(sp_q) + 5'h01 && tos_raw == $past(stk_val)) else $error("push order wrong");
  a_ovf_flag: assert property (ovf_ev |=> ovf_q) else $error("overflow flag missed");
  a_empty_zero: assert property (sp_q == `PCS_SP_EMPTY && I_STACK_FAULT_RESET_EN |->
    tos_rd == 15'h0000) else $error("empty stack not zero");
  a_fault_reset: assert property ((ovf_ev || unf_ev) |=>
    O_STACK_FAULT_RST == $past(I_STACK_FAULT_RESET_EN)) else $error("fault reset wrong");
  a_pcl_write: assert property (pcl_wr |=>
    pc_q == {$past(latch_q), $past(I_REG_WDATA)}) else $error("low byte write wrong");

  sequence s_flash_req;
    st_q == pcs_pkg::ST_IDLE && I_IND_REQ && is_flash && !I_IND_WR;
  endsequence
  sequence s_flash_run;
    O_FLASH_RD ##1 !O_IND_DONE[*2] ##1 O_IND_DONE;
  endsequence
  a_flash_cycle: assert property (s_flash_req |=> s_flash_run)
    else $error("flash access timing wrong");
  a_self_nowr: assert property (st_q == pcs_pkg::ST_IDLE && I_IND_REQ && is_zero |=>
    !O_MEM_WR ##2 O_IND_DONE && O_IND_RDATA == 8'h00) else $error("self access not blocked");
endmodule

// file: sim/pcs_mem_model.sv
// Data memory and read-only program flash behind the indirect port.
// Assumes the core's registered strobes and addresses on the same clock.
`timescale 1ns/1ns
module pcs_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Data memory
  input  wire logic [11:0] i_mem_addr,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic [7:0]  i_mem_wdata,
  output logic [7:0]       o_mem_rdata = 8'h5A,
  // Program flash
  input  wire logic [14:0] i_flash_addr,
  input  wire logic        i_flash_rd,
  output logic [13:0]      o_flash_rdata = 14'h0F0F
);
  logic [7:0]  mem [0:4095];
  logic [13:0] fa_q;
  logic        fwait_q = 1'b0;

  // Data one cycle after the strobe; toggles otherwise so stale data never matches
  always_ff @(posedge i_clk)
  begin
    if (i_mem_wr)
      mem[i_mem_addr] <= i_mem_wdata;
    o_mem_rdata <= i_mem_rd ? mem[i_mem_addr] : ~o_mem_rdata;
  end

  // Flash answers two cycles after the strobe; no write path exists
  always_ff @(posedge i_clk)
  begin
    fwait_q <= i_flash_rd;
    if (i_flash_rd)
      fa_q <= i_flash_addr[13:0];
    o_flash_rdata <= fwait_q ? (fa_q ^ 14'h15A5) : ~o_flash_rdata;
  end
endmodule

// file: sim/pcs_core_tb.sv
// Self-checking bench: counter loads, return stack and indirect accesses.
// Assumes pcs_pkg, pcs_core and pcs_mem_model are compiled before it.
`timescale 1ns/1ns
`include "pcs_consts.svh"
module pcs_core_tb;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             por = 1'b1;
  logic             fre = 1'b0;
  logic             op_v = 1'b0;
  pcs_pkg::pcs_op_t op = pcs_pkg::OP_NONE;
  logic [10:0]      opnd = 11'h000;
  logic [7:0]       wreg = 8'h00;
  logic [3:0]       ra = 4'h0;
  logic [7:0]       rwd = 8'h00;
  logic             rwr = 1'b0;
  logic             rrd = 1'b0;
  logic             ireq = 1'b0;
  logic             isel = 1'b0;
  logic             iwr = 1'b0;
  logic [7:0]       iwd = 8'h00;
  wire logic [7:0]  rdata, irdata, mrdata, mwd;
  wire logic [14:0] pc, faddr;
  wire logic [11:0] maddr;
  wire logic [13:0] frdata;
  wire logic        flt, busy, done, mrd, mwr, frd;
  // Behavioural model state
  int               m_pc, m_lat, m_sp, m_ovf, m_unf, m_ev, m_stk [16];
  int               num_errors, cmp_count, g_n, g_s, g_a, n_data, i, v;
  int               seed = 17;
  logic [7:0]       d;
  pcs_pkg::pcs_op_t ops [8] = '{pcs_pkg::OP_STEP, pcs_pkg::OP_CALL, pcs_pkg::OP_COMPUTED_CALL_OP, pcs_pkg::OP_BRW,
                                pcs_pkg::OP_BRA, pcs_pkg::OP_INTR, pcs_pkg::OP_RET, pcs_pkg::OP_RET};

  // 125 MHz core clock
  always #4 clk = ~clk;

  pcs_core DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_POR_RST(por), .I_STACK_FAULT_RESET_EN(fre),
    .I_OP_VALID(op_v), .I_OP(op), .I_OPERAND(opnd), .I_WREG(wreg), .I_REG_ADDR(ra), .I_REG_WDATA(rwd),
    .I_REG_WR(rwr), .I_REG_RD(rrd), .O_REG_RDATA(rdata), .O_PC(pc), .O_STACK_FAULT_RST(flt),
    .I_IND_REQ(ireq), .I_IND_SEL(isel), .I_IND_WR(iwr), .I_IND_WDATA(iwd), .O_IND_BUSY(busy),
    .O_IND_DONE(done), .O_IND_RDATA(irdata), .O_MEM_ADDR(maddr), .O_MEM_RD(mrd), .O_MEM_WR(mwr),
    .O_MEM_WDATA(mwd), .I_MEM_RDATA(mrdata), .O_FLASH_ADDR(faddr), .O_FLASH_RD(frd),
    .I_FLASH_RDATA(frdata));

  pcs_mem_model mem_far (.i_clk(clk), .i_mem_addr(maddr), .i_mem_rd(mrd), .i_mem_wr(mwr),
    .i_mem_wdata(mwd), .o_mem_rdata(mrdata), .i_flash_addr(faddr), .i_flash_rd(frd),
    .o_flash_rdata(frdata));

  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare tasks for counter values and byte results
  task automatic chk15(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t counter got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  // Register port write, model follows the same effect
  task automatic wr(input logic [3:0] a, input logic [7:0] dd);
    @(posedge clk);
    rwr <= 1'b1;
    ra <= a;
    rwd <= dd;
    @(posedge clk);
    rwr <= 1'b0;
    #1;
    case (a)
      `PCS_A_LATCH: m_lat = dd & 127;
      `PCS_A_PCL:   m_pc = (m_lat << 8) | dd;
      `PCS_A_SP:    m_sp = dd & 31;
      `PCS_A_TOP_OF_STACK_LOW:  m_stk[m_sp & 15] = (m_stk[m_sp & 15] & 32512) | dd;
      `PCS_A_TOP_OF_STACK_HIGH:  m_stk[m_sp & 15] = (m_stk[m_sp & 15] & 255) | ((dd & 127) << 8);
      `PCS_A_PWR:   {m_ovf, m_unf} = {m_ovf & dd[1], m_unf & dd[0]};
      default:      ;
    endcase
  endtask

  // Register port read, data checked in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rrd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask

  task automatic push(input int pv);
    if (m_sp >= 15 && m_sp <= 30)
      {m_ovf, m_ev} = {32'd1, 32'd1};
    m_sp = (m_sp + 1) & 31;
    m_stk[m_sp & 15] = pv & 32767;
  endtask

  // One decoder operation, checked against the model one cycle later
  task automatic do_op(input pcs_pkg::pcs_op_t o, input logic [10:0] n, input logic [7:0] w);
    m_ev = 0;
    case (o)
      pcs_pkg::OP_STEP:  m_pc = m_pc + 1;
      pcs_pkg::OP_CALL:  {v, m_pc} = {m_pc + 1, ((m_lat >> 3) << 11) | n};
      pcs_pkg::OP_COMPUTED_CALL_OP: {v, m_pc} = {m_pc + 1, (m_lat << 8) | w};
      pcs_pkg::OP_BRW:   m_pc = m_pc + 1 + w;
      pcs_pkg::OP_BRA:   m_pc = m_pc + 1 + (n[8] ? int'(n[8:0]) - 512 : int'(n[8:0]));
      pcs_pkg::OP_INTR:  {v, m_pc} = {m_pc, 32'd4};
      default:           ;
    endcase
    if (o == pcs_pkg::OP_CALL || o == pcs_pkg::OP_COMPUTED_CALL_OP || o == pcs_pkg::OP_INTR)
      push(v);
    if (o == pcs_pkg::OP_RET)
    begin
      if (m_sp == 31)
        {m_unf, m_ev} = {32'd1, 32'd1};
      m_pc = m_stk[m_sp & 15];
      m_sp = (m_sp - 1) & 31;
    end
    m_pc = m_pc & 32767;
    @(posedge clk);
    op_v <= 1'b1;
    op <= o;
    opnd <= n;
    wreg <= w;
    @(posedge clk);
    op_v <= 1'b0;
    #1;
    chk8({7'h00, flt}, {7'h00, fre & (m_ev != 0)});
    if (!(fre && m_ev != 0))
      chk15(pc, 15'(m_pc));
  endtask

  task automatic setp(input logic s, input logic [15:0] p);
    wr(s ? `PCS_A_F1L : `PCS_A_F0L, p[7:0]);
    wr(s ? `PCS_A_F1H : `PCS_A_F0H, p[15:8]);
  endtask

  // Indirect access; counts cycles to done and memory strobes seen
  task automatic ind(input logic s, input logic w, input logic [7:0] dd, input logic [7:0] exp);
    {g_n, g_s} = {32'd0, 32'd0};
    @(posedge clk);
    ireq <= 1'b1;
    isel <= s;
    iwr <= w;
    iwd <= dd;
    for (int k = 0; k < 20 && g_n == 0; k++)
    begin
      @(posedge clk);
      ireq <= 1'b0;
      #1;
      if (k == 0)
        chk8({7'h00, busy}, 8'h01);
      if (mrd === 1'b1 || mwr === 1'b1 || frd === 1'b1)
        {g_s, g_a} = {g_s + 1, int'(maddr)};
      if (done === 1'b1)
        g_n = k + 1;
    end
    if (g_n == 0)
    begin
      num_errors++;
      $display("[ERR] t=%0t indirect access never completed", $time);
      finish_test();
    end
    if (!w)
      chk8(irdata, exp);
  endtask

  // Main sequence
  initial
  begin
    foreach (m_stk[j]) m_stk[j] = 0;
    {m_pc, m_lat, m_sp, m_ovf, m_unf} = {32'd0, 32'd0, 32'd31, 32'd0, 32'd0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    #1;
    chk15(pc, 15'h0000);
    rd(`PCS_A_SP, 8'h1F);
    wr(`PCS_A_LATCH, 8'($random(seed)));
    wr(`PCS_A_PCL, 8'($random(seed)));
    chk15(pc, 15'(m_pc));
    for (i = 0; i < 16; i++)
      do_op(ops[i % 8], 11'($random(seed)), 8'($random(seed)));
    rd(`PCS_A_SP, 8'(m_sp));
    wr(`PCS_A_PCL, 8'h3C);
    chk15(pc, 15'(m_pc));
    for (i = 0; i < 17; i++)
      do_op(pcs_pkg::OP_CALL, 11'($random(seed)), 8'h00);
    rd(`PCS_A_PWR, 8'({m_ovf[0], m_unf[0]}));
    wr(`PCS_A_SP, 8'h00);
    rd(`PCS_A_TOP_OF_STACK_LOW, 8'(m_stk[0]));
    rd(`PCS_A_TOP_OF_STACK_HIGH, 8'(m_stk[0] >> 8));
    wr(`PCS_A_SP, 8'h05);
    wr(`PCS_A_TOP_OF_STACK_LOW, 8'($random(seed)));
    wr(`PCS_A_TOP_OF_STACK_HIGH, 8'hFF);
    do_op(pcs_pkg::OP_RET, 11'h000, 8'h00);
    wr(`PCS_A_PWR, 8'h00);
    rd(`PCS_A_PWR, 8'h00);
    wr(`PCS_A_SP, 8'h1F);
    rd(`PCS_A_TOP_OF_STACK_LOW, 8'(m_stk[15]));
    @(posedge clk);
    fre <= 1'b1;
    rd(`PCS_A_TOP_OF_STACK_LOW, 8'h00);
    rd(`PCS_A_TOP_OF_STACK_HIGH, 8'h00);
    do_op(pcs_pkg::OP_RET, 11'h000, 8'h00);
    wr(`PCS_A_SP, 8'h0F);
    do_op(pcs_pkg::OP_CALL, 11'h123, 8'h00);
    rd(`PCS_A_PWR, 8'h03);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    {m_pc, m_lat, m_sp} = {32'd0, 32'd0, 32'd31};
    chk15(pc, 15'h0000);
    rd(`PCS_A_SP, 8'h1F);
    rd(`PCS_A_PWR, 8'h03);
    d = 8'($random(seed));
    setp(1'b0, 16'h2050);
    ind(1'b0, 1'b1, d, 8'h00);
    chk15(15'(g_a), 15'h00A0);
    setp(1'b1, 16'h00A0);
    ind(1'b1, 1'b0, 8'h00, d);
    n_data = g_n;
    setp(1'b0, 16'h204F);
    ind(1'b0, 1'b1, ~d, 8'h00);
    chk15(15'(g_a), 15'h006F);
    setp(1'b0, 16'h0F81);
    ind(1'b0, 1'b0, 8'h00, 8'h00);
    ind(1'b0, 1'b1, d, 8'h00);
    chk8(8'(g_s), 8'h00);
    setp(1'b1, 16'h29B0);
    ind(1'b1, 1'b0, 8'h00, 8'h00);
    chk8(8'(g_s), 8'h00);
    setp(1'b0, 16'h9234);
    ind(1'b0, 1'b0, 8'h00, 8'(16'h1234 ^ 16'h15A5));
    chk8(8'(g_n), 8'(n_data + 1));
    ind(1'b0, 1'b1, d, 8'h00);
    chk8(8'(g_s), 8'h00);
    finish_test();
  end
endmodule
